// file: hdl/ppnvm_port.sv
/*
 parallel programming port of the nonvolatile memories: command, address
 and data loading, page buffers, page writes, fuse and lock writes,
 chip erase and all read-back paths.
 assumes the programmer's pins are synchronous to ref_clk_in and that
 each strobe level is held for at least one clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ppnvm_consts.svh"
module ppnvm_port import ppnvm_pkg::*; #(
   parameter int FA = 14, // flash word address bits
   parameter int FPW = 6, // flash page offset bits
   parameter int EA = 10, // eeprom address bits
   parameter int EPW = 2, // eeprom page offset bits
   parameter int PROG_CYCLES = `PPNVM_PROG_CYCLES,
   parameter logic [7:0] SIG0 = 8'h5A, // arbitrary identification value
   parameter logic [7:0] SIG1 = 8'h3C, // arbitrary identification value
   parameter logic [7:0] SIG2 = 8'h01, // arbitrary identification value
   parameter logic [7:0] CALIB = 8'h80 // calibration byte
) (
   input wire logic ref_clk_in, // 20 MHz clock
   input wire logic resetn_in, // sync reset, low
   input wire logic [7:0] data_in, // data bus from pins
   output logic [7:0] data_out, // data bus to pins
   output logic data_oe_out, // high while driving bus
   input wire logic oe_n_in, // output enable, low
   input wire logic prog_strobe_n_in, // program strobe, low
   input wire logic load_strobe_in, // load strobe, rising
   input wire logic buffer_latch_strobe_in, // page latch, rising
   input wire logic action_select_hi_in, // action select bit 1
   input wire logic action_select_lo_in, // action select bit 0
   input wire logic byte_select_one_in, // byte select bit 0
   input wire logic byte_select_two_in, // byte select bit 1
   output logic done_flag_out // high when ready
);
   localparam int CW = (FA > EA) ? FA : EA;
   localparam logic [CW:0] FPG = {{CW{1'b0}}, 1'b1} << FPW;
   localparam logic [CW:0] EPG = {{CW{1'b0}}, 1'b1} << EPW;
   localparam logic [CW:0] FDEP = {{CW{1'b0}}, 1'b1} << FA;
   localparam logic [CW:0] EDEP = {{CW{1'b0}}, 1'b1} << EA;
   localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);
   localparam logic [CW:0] ELAST = ((FDEP > EDEP) ? FDEP : EDEP) - {{CW{1'b0}}, 1'b1};

   function automatic logic is_write(input logic [7:0] c);
      is_write = (c == `PPNVM_CMD_WR_FLASH) || (c == `PPNVM_CMD_WR_EEP) ||
         (c == `PPNVM_CMD_WR_FUSE) || (c == `PPNVM_CMD_WR_LOCK) ||
         (c == `PPNVM_CMD_ERASE);
   endfunction

   ppnvm_state_e state;
   logic ready;
   logic [CW:0] cnt;
   logic [CW:0] cnt_m1;
   logic [15:0] wcnt;
   ppnvm_byte_t cmd;
   ppnvm_byte_t addr_lo;
   ppnvm_byte_t addr_hi;
   ppnvm_byte_t addr_ext;
   ppnvm_byte_t dat_lo;
   ppnvm_byte_t dat_hi;
   ppnvm_byte_t fuse_lo;
   ppnvm_byte_t fuse_hi;
   ppnvm_byte_t fuse_ext;
   ppnvm_byte_t lock;
   logic load_q;
   logic latch_q;
   logic prog_q;
   logic load_rise;
   logic latch_rise;
   logic prog_fall;
   logic [1:0] act;
   logic [1:0] bsel;
   logic start;
   logic [FA-1:0] faddr;
   logic [EA-1:0] eaddr;
   logic fbuf_we;
   logic ebuf_we;
   logic [15:0] fbuf_rd;
   logic [7:0] ebuf_rd;
   logic farr_we;
   logic earr_we;
   logic [FA-1:0] farr_wa;
   logic [EA-1:0] earr_wa;
   logic [15:0] farr_wd;
   logic [7:0] earr_wd;
   logic [15:0] farr_rd;
   logic [7:0] earr_rd;
   logic [CW:0] page_last;
   ppnvm_byte_t next_data;
   ppnvm_byte_t next_lock;

   assign act = {action_select_hi_in, action_select_lo_in};
   assign bsel = {byte_select_two_in, byte_select_one_in};
   assign load_rise = load_strobe_in & ~load_q;
   assign latch_rise = buffer_latch_strobe_in & ~latch_q;
   assign prog_fall = ~prog_strobe_n_in & prog_q;
   assign faddr = FA'({addr_ext, addr_hi, addr_lo});
   assign eaddr = EA'({addr_hi, addr_lo});
   assign cnt_m1 = cnt - {{CW{1'b0}}, 1'b1};
   assign done_flag_out = ready;

   // strobes are edge-detected so a held level acts only once
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         load_q <= 1'b0;
         latch_q <= 1'b0;
         prog_q <= 1'b1;
      end else begin
         load_q <= load_strobe_in;
         latch_q <= buffer_latch_strobe_in;
         prog_q <= prog_strobe_n_in;
      end
   end

   // loads are ignored while busy; values persist across operations
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         cmd <= `PPNVM_CMD_NOP;
         addr_lo <= 8'h00;
         addr_hi <= 8'h00;
         addr_ext <= 8'h00;
         dat_lo <= 8'h00;
         dat_hi <= 8'h00;
      end else if (load_rise && ready) begin
         case (act)
            `PPNVM_ACT_ADDR: begin
               case (bsel)
                  `PPNVM_BS_LOW: addr_lo <= data_in;
                  `PPNVM_BS_HIGH: addr_hi <= data_in;
                  `PPNVM_BS_EXT: addr_ext <= data_in;
                  default: ;
               endcase
            end
            `PPNVM_ACT_DATA: begin
               if (byte_select_one_in) begin
                  dat_hi <= data_in;
               end else begin
                  dat_lo <= data_in;
               end
            end
            `PPNVM_ACT_CMD: cmd <= data_in;
            default: ;
         endcase
      end
   end

   // page buffers fill on the latch strobe
   assign fbuf_we = latch_rise && ready && (cmd == `PPNVM_CMD_WR_FLASH);
   assign ebuf_we = latch_rise && ready && (cmd == `PPNVM_CMD_WR_EEP);

   // a write starts only with a write command loaded and the port idle
   assign start = prog_fall && ready && is_write(cmd);

   always_comb begin
      if (cmd == `PPNVM_CMD_WR_FLASH) begin
         page_last = FPG;
      end else begin
         page_last = EPG;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state <= PPNVM_IDLE;
         ready <= 1'b1;
         cnt <= '0;
         wcnt <= 16'h0000;
      end else begin
         case (state)
            PPNVM_IDLE: begin
               cnt <= '0;
               wcnt <= 16'h0000;
               if (start) begin
                  case (cmd)
                     `PPNVM_CMD_WR_FLASH, `PPNVM_CMD_WR_EEP: begin
                        // page write needs byte select low
                        if (bsel == `PPNVM_BS_LOW) begin
                           state <= PPNVM_COPY;
                           ready <= 1'b0;
                        end
                     end
                     `PPNVM_CMD_ERASE: begin
                        state <= PPNVM_ERASE;
                        ready <= 1'b0;
                     end
                     default: begin
                        state <= PPNVM_WAIT;
                        ready <= 1'b0;
                     end
                  endcase
               end
            end
            PPNVM_COPY: begin
               // one buffer word per cycle; writes trail reads by one
               cnt <= cnt + {{CW{1'b0}}, 1'b1};
               if (cnt == page_last) begin
                  state <= PPNVM_WAIT;
               end
            end
            PPNVM_ERASE: begin
               cnt <= cnt + {{CW{1'b0}}, 1'b1};
               if (cnt == ELAST) begin
                  state <= PPNVM_WAIT;
               end
            end
            PPNVM_WAIT: begin
               wcnt <= wcnt + 16'h0001;
               if (wcnt == PROG_LAST) begin
                  state <= PPNVM_IDLE;
                  ready <= 1'b1;
               end
            end
            default: begin
               state <= PPNVM_IDLE;
               ready <= 1'b1;
            end
         endcase
      end
   end

   // array write ports
   always_comb begin
      farr_we = 1'b0;
      earr_we = 1'b0;
      farr_wa = faddr;
      earr_wa = eaddr;
      farr_wd = fbuf_rd;
      earr_wd = ebuf_rd;
      if (state == PPNVM_ERASE) begin
         // one sweep as long as the larger array erases both
         farr_we = (cnt < FDEP);
         farr_wa = cnt[FA-1:0];
         farr_wd = `PPNVM_ERASED_WORD;
         earr_we = (cnt < EDEP);
         earr_wa = cnt[EA-1:0];
         earr_wd = `PPNVM_ERASED_BYTE;
      end else if (state == PPNVM_COPY && cnt != '0) begin
         if (cmd == `PPNVM_CMD_WR_FLASH) begin
            farr_we = 1'b1;
            farr_wa = {faddr[FA-1:FPW], cnt_m1[FPW-1:0]};
         end else begin
            earr_we = 1'b1;
            earr_wa = {eaddr[EA-1:EPW], cnt_m1[EPW-1:0]};
         end
      end
   end

   ppnvm_mem #(.DW(16), .AW(FPW)) u_fbuf (
      .ref_clk_in(ref_clk_in),
      .wr_en_in(fbuf_we),
      .wr_addr_in(faddr[FPW-1:0]),
      .wr_data_in({dat_hi, dat_lo}),
      .rd_addr_in(cnt[FPW-1:0]),
      .rd_data_out(fbuf_rd)
   );

   ppnvm_mem #(.DW(8), .AW(EPW)) u_ebuf (
      .ref_clk_in(ref_clk_in),
      .wr_en_in(ebuf_we),
      .wr_addr_in(eaddr[EPW-1:0]),
      .wr_data_in(dat_lo),
      .rd_addr_in(cnt[EPW-1:0]),
      .rd_data_out(ebuf_rd)
   );

   ppnvm_mem #(.DW(16), .AW(FA)) u_farr (
      .ref_clk_in(ref_clk_in),
      .wr_en_in(farr_we),
      .wr_addr_in(farr_wa),
      .wr_data_in(farr_wd),
      .rd_addr_in(faddr),
      .rd_data_out(farr_rd)
   );

   ppnvm_mem #(.DW(8), .AW(EA)) u_earr (
      .ref_clk_in(ref_clk_in),
      .wr_en_in(earr_we),
      .wr_addr_in(earr_wa),
      .wr_data_in(earr_wd),
      .rd_addr_in(eaddr),
      .rd_data_out(earr_rd)
   );

   // lock bits only ever go 0-ward here
   always_comb begin
      next_lock = lock & dat_lo;
      if (lock[1:0] == 2'b00) begin
         next_lock[5:2] = lock[5:2];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         fuse_lo <= `PPNVM_FUSE_LO_RST;
         fuse_hi <= `PPNVM_FUSE_HI_RST;
         fuse_ext <= `PPNVM_FUSE_EXT_RST;
      end else if (start && cmd == `PPNVM_CMD_WR_FUSE) begin
         case (bsel)
            `PPNVM_BS_LOW: fuse_lo <= dat_lo;
            `PPNVM_BS_HIGH: fuse_hi <= dat_lo;
            `PPNVM_BS_EXT: fuse_ext <= dat_lo;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         lock <= `PPNVM_LOCK_RST;
      end else if (state == PPNVM_ERASE && cnt == ELAST) begin
         // released only once the whole erase sweep over both arrays is done
         lock <= `PPNVM_LOCK_RST;
      end else if (start && cmd == `PPNVM_CMD_WR_LOCK) begin
         lock <= next_lock;
      end
   end

   // read-back mux; array data is already one cycle late
   always_comb begin
      next_data = `PPNVM_ERASED_BYTE;
      case (cmd)
         `PPNVM_CMD_RD_FLASH: begin
            next_data = byte_select_one_in ? farr_rd[15:8] : farr_rd[7:0];
         end
         `PPNVM_CMD_RD_EEP: next_data = earr_rd;
         `PPNVM_CMD_RD_FUSE: begin
            case (bsel)
               `PPNVM_BS_LOW: next_data = fuse_lo;
               `PPNVM_BS_RES: next_data = fuse_hi;
               `PPNVM_BS_EXT: next_data = fuse_ext;
               default: next_data = lock;
            endcase
         end
         `PPNVM_CMD_RD_SIG: begin
            if (byte_select_one_in) begin
               if (addr_lo == 8'h00) begin
                  next_data = CALIB;
               end
            end else begin
               case (addr_lo)
                  8'h00: next_data = SIG0;
                  8'h01: next_data = SIG1;
                  8'h02: next_data = SIG2;
                  default: ;
               endcase
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         data_out <= 8'h00;
      end else begin
         data_out <= next_data;
      end
   end

   // bus turns around with output enable alone, no clock delay
   assign data_oe_out = ~oe_n_in;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   a_ext_addr_load: assert property (
      load_rise && ready && act == `PPNVM_ACT_ADDR && bsel == `PPNVM_BS_EXT
      |=> addr_ext == $past(data_in))
      else $error("extended address not loaded");

   a_flash_page_busy: assert property (
      start && cmd == `PPNVM_CMD_WR_FLASH && bsel == `PPNVM_BS_LOW
      |=> !done_flag_out && state == PPNVM_COPY)
      else $error("flash page write did not start");

   a_eep_page_len: assert property (
      start && cmd == `PPNVM_CMD_WR_EEP && bsel == `PPNVM_BS_LOW
      |=> !done_flag_out [*5] ##1 state == PPNVM_WAIT)
      else $error("eeprom page copy length wrong");

   a_nop_load: assert property (
      load_rise && ready && !prog_fall && act == `PPNVM_ACT_CMD && data_in == `PPNVM_CMD_NOP
      |=> cmd == `PPNVM_CMD_NOP ##1 done_flag_out)
      else $error("nop did not end writing");

   a_idle_ignore: assert property (
      prog_fall && ready && !is_write(cmd) |=> done_flag_out && $stable(lock))
      else $error("program strobe acted without write command");

   a_fuse_high: assert property (
      start && cmd == `PPNVM_CMD_WR_FUSE && bsel == `PPNVM_BS_HIGH
      |=> fuse_hi == $past(dat_lo) && $stable(fuse_lo))
      else $error("high fuse not written");

   a_fuse_ext: assert property (
      start && cmd == `PPNVM_CMD_WR_FUSE && bsel == `PPNVM_BS_EXT
      |=> fuse_ext == $past(dat_lo) && $stable(fuse_hi))
      else $error("extended fuse not written");

   a_fuse_low: assert property (
      start && cmd == `PPNVM_CMD_WR_FUSE && bsel == `PPNVM_BS_LOW
      |=> fuse_lo == $past(dat_lo) ##1 !done_flag_out)
      else $error("low fuse not written");

   a_lock_oneway: assert property (
      state != PPNVM_ERASE |=> (lock & ~$past(lock)) == 8'h00)
      else $error("lock bit released without erase");

   a_boot_lock_hold: assert property (
      lock[1:0] == 2'b00 |=> lock[5:2] == $past(lock[5:2]) || $past(state) == PPNVM_ERASE)
      else $error("boot lock changed at level 3");

   a_drive_oe: assert property (
      data_oe_out == !oe_n_in)
      else $error("bus driven with output enable high");

   a_sig_read: assert property (
      cmd == `PPNVM_CMD_RD_SIG && !byte_select_one_in && addr_lo == 8'h01
      |=> data_out == SIG1)
      else $error("signature byte wrong");

   a_calib_read: assert property (
      cmd == `PPNVM_CMD_RD_SIG && byte_select_one_in && addr_lo == 8'h00
      |=> data_out == CALIB)
      else $error("calibration byte wrong");

   a_lock_read: assert property (
      cmd == `PPNVM_CMD_RD_FUSE && bsel == `PPNVM_BS_HIGH |=> data_out == $past(lock))
      else $error("lock read wrong");
endmodule
`default_nettype wire

// file: hdl/ppnvm_consts.svh
/*
 constants of the parallel programming port: command codes, byte-select
 codes, reset and erased values, timing counts.
 assumes it is included by its bare name from design files.
*/
`ifndef PPNVM_CONSTS_SVH
`define PPNVM_CONSTS_SVH

// command bytes
`define PPNVM_CMD_NOP 8'h00
`define PPNVM_CMD_ERASE 8'h80
`define PPNVM_CMD_WR_FUSE 8'h40
`define PPNVM_CMD_WR_LOCK 8'h20
`define PPNVM_CMD_WR_FLASH 8'h10
`define PPNVM_CMD_WR_EEP 8'h11
`define PPNVM_CMD_RD_SIG 8'h08
`define PPNVM_CMD_RD_FUSE 8'h04
`define PPNVM_CMD_RD_FLASH 8'h02
`define PPNVM_CMD_RD_EEP 8'h03

// action select {hi,lo}
`define PPNVM_ACT_ADDR 2'h0
`define PPNVM_ACT_DATA 2'h1
`define PPNVM_ACT_CMD 2'h2

// byte select {two,one}
`define PPNVM_BS_LOW 2'h0
`define PPNVM_BS_HIGH 2'h1
`define PPNVM_BS_EXT 2'h2
`define PPNVM_BS_RES 2'h3

// reset and erased contents
`define PPNVM_ERASED_BYTE 8'hFF
`define PPNVM_ERASED_WORD 16'hFFFF
`define PPNVM_FUSE_LO_RST 8'hFF
`define PPNVM_FUSE_HI_RST 8'hFF
`define PPNVM_FUSE_EXT_RST 8'hFF
`define PPNVM_LOCK_RST 8'hFF

// busy time after a write, in clock cycles
`define PPNVM_PROG_CYCLES 16

`endif

// file: hdl/ppnvm_pkg.sv
/*
 types of the parallel programming port.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ppnvm_pkg;
   typedef enum logic [3:0] {
      PPNVM_IDLE  = 4'b0001,
      PPNVM_COPY  = 4'b0010,
      PPNVM_ERASE = 4'b0100,
      PPNVM_WAIT  = 4'b1000
   } ppnvm_state_e;
   typedef logic [7:0] ppnvm_byte_t;
endpackage
`default_nettype wire

// file: hdl/ppnvm_mem.sv
/*
 simple dual-port memory: one write port, one read port with registered
 read data. used for page buffers and the arrays themselves.
 assumes a single clock; contents have no reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ppnvm_mem #(
   parameter int DW = 8,
   parameter int AW = 4
) (
   input wire logic ref_clk_in, // clock
   input wire logic wr_en_in, // write strobe
   input wire logic [AW-1:0] wr_addr_in, // write address
   input wire logic [DW-1:0] wr_data_in, // write data
   input wire logic [AW-1:0] rd_addr_in, // read address
   output logic [DW-1:0] rd_data_out // read data, one cycle late
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      rd_data_out <= mem[rd_addr_in];
   end
endmodule
`default_nettype wire

// file: bench/ppnvm_prog_model.sv
/*
 behavioural model of the external parallel programmer: drives the action
 and byte selects, the strobes and the data bus, and reads the bus back.
 assumes one clock shared with the port; pins change 2 ns after its edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ppnvm_prog_model (
   input wire logic clk_in, // device clock
   input wire logic done_flag_in, // ready flag from the port
   input wire logic [7:0] bus_in, // resolved data bus
   output logic [7:0] data_out, // data driven while oe_n is high
   output logic oe_n_out, // output enable, low
   output logic prog_n_out, // program strobe, low
   output logic load_out, // load strobe
   output logic latch_out, // buffer latch strobe
   output logic [1:0] act_out, // action select {hi,lo}
   output logic [1:0] bs_out // byte select {two,one}
);
   initial begin
      data_out = 8'h00;
      oe_n_out = 1'b1;
      prog_n_out = 1'b1;
      load_out = 1'b0;
      latch_out = 1'b0;
      act_out = 2'h3;
      bs_out = 2'h0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask

   task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
      act_out = act;
      bs_out = bs;
      data_out = d;
      tick(1);
      load_out = 1'b1;
      tick(1);
      load_out = 1'b0;
      tick(1);
   endtask

   task automatic latch();
      latch_out = 1'b1;
      tick(1);
      latch_out = 1'b0;
      tick(1);
   endtask

   // strobe held three cycles, long enough to see the flag drop
   task automatic program_page(input logic [1:0] bs, output logic went_busy, output logic back);
      int n;
      bs_out = bs;
      tick(1);
      prog_n_out = 1'b0;
      went_busy = 1'b0;
      for (n = 0; n < 3; n++) begin
         tick(1);
         if (done_flag_in === 1'b0) went_busy = 1'b1;
      end
      prog_n_out = 1'b1;
      back = 1'b0;
      for (n = 0; n < 2000 && !back; n++) begin
         tick(1);
         back = (done_flag_in === 1'b1);
      end
   endtask

   // released bus shows the inverse of our last value, so a silent device is seen
   task automatic read(input logic [1:0] bs, output logic [7:0] d);
      bs_out = bs;
      data_out = ~data_out;
      oe_n_out = 1'b0;
      tick(3);
      d = bus_in;
      oe_n_out = 1'b1;
      tick(1);
   endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
 self-checking bench of the parallel programming port: flash, eeprom,
 fuse and lock writes, chip erase and every read path.
 assumes the programmer model and the port share one 20 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [1:0] A_ADR = 2'h0;
   localparam logic [1:0] A_DAT = 2'h1;
   localparam logic [1:0] A_CMD = 2'h2;
   localparam logic [1:0] A_NOP = 2'h3;
   localparam logic [7:0] CAL = 8'h9e; // arbitrary value
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] bus, prog_data, data_out;
   logic data_oe_out, done_flag_out, oe_n, prog_n, load, latch;
   logic [1:0] act, bs;
   int n_mismatch = 0;
   int cmp_count = 0;

   always #25 ref_clk_in = ~ref_clk_in;
   assign bus = data_oe_out ? data_out : prog_data;

   // a small flash; the erase sweep still runs over all 1024 eeprom addresses
   ppnvm_port #(.FA(8), .SIG0(8'h6b), .SIG1(8'h27), .SIG2(8'hc4), .CALIB(CAL))
      ppnvm_port_inst (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .data_in(bus),
      .data_out(data_out), .data_oe_out(data_oe_out), .oe_n_in(oe_n),
      .prog_strobe_n_in(prog_n), .load_strobe_in(load), .buffer_latch_strobe_in(latch),
      .action_select_hi_in(act[1]), .action_select_lo_in(act[0]),
      .byte_select_one_in(bs[0]), .byte_select_two_in(bs[1]),
      .done_flag_out(done_flag_out));

   ppnvm_prog_model ppnvm_prog_model_inst (
      .clk_in(ref_clk_in), .done_flag_in(done_flag_out), .bus_in(bus),
      .data_out(prog_data), .oe_n_out(oe_n), .prog_n_out(prog_n), .load_out(load),
      .latch_out(latch), .act_out(act), .bs_out(bs));

   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
      ppnvm_prog_model_inst.load(a, b, d);
   endtask

   task automatic rd(input logic [1:0] b, input string name, input logic [7:0] exp);
      logic [7:0] d;
      ppnvm_prog_model_inst.read(b, d);
      check(name, d, exp);
      check("bus released", {7'h00, data_oe_out}, 8'h00);
   endtask

   task automatic pg(input logic [1:0] b, input logic exp_busy);
      logic went, back;
      ppnvm_prog_model_inst.program_page(b, went, back);
      check("busy seen", {7'h00, went}, {7'h00, exp_busy});
      check("ready back", {7'h00, back}, 8'h01);
   endtask

   task automatic t_reset();
      check("ready after reset", {7'h00, done_flag_out}, 8'h01);
      ld(A_CMD, 2'h0, 8'h04);
      rd(2'h0, "fuse low", 8'hff);
      rd(2'h3, "fuse high", 8'hff);
      rd(2'h2, "fuse ext", 8'hff);
      rd(2'h1, "lock", 8'hff);
   endtask

   task automatic t_flash();
      ld(A_CMD, 2'h0, 8'h10);
      for (int i = 0; i < 2; i++) begin
         ld(A_ADR, 2'h0, 8'h08 + 8'(i));
         ld(A_DAT, 2'h0, 8'h34 ^ 8'(i));
         ld(A_DAT, 2'h1, 8'h12 ^ 8'(i));
         ppnvm_prog_model_inst.latch();
      end
      ld(A_ADR, 2'h1, 8'h00);
      ld(A_ADR, 2'h2, 8'h00);
      pg(2'h0, 1'b1);
      ld(A_CMD, 2'h0, 8'h00);
      pg(2'h0, 1'b0);
      ld(A_CMD, 2'h0, 8'h02);
      for (int i = 0; i < 2; i++) begin
         ld(A_ADR, 2'h0, 8'h08 + 8'(i));
         rd(2'h0, "flash low", 8'h34 ^ 8'(i));
         rd(2'h1, "flash high", 8'h12 ^ 8'(i));
      end
   endtask

   task automatic t_eeprom();
      ld(A_CMD, 2'h0, 8'h11);
      ld(A_ADR, 2'h1, 8'h00);
      for (int i = 0; i < 2; i++) begin
         ld(A_ADR, 2'h0, 8'h05 + 8'(i));
         ld(A_DAT, 2'h0, 8'hc3 ^ 8'(i));
         ppnvm_prog_model_inst.latch();
      end
      pg(2'h0, 1'b1);
      ld(A_CMD, 2'h0, 8'h03);
      for (int i = 0; i < 2; i++) begin
         ld(A_ADR, 2'h0, 8'h05 + 8'(i));
         rd(2'h0, "eeprom", 8'hc3 ^ 8'(i));
      end
   endtask

   task automatic t_fuse();
      logic [7:0] v[3] = '{8'he1, 8'hd2, 8'hf4};
      for (int i = 0; i < 3; i++) begin
         ld(A_CMD, 2'h0, 8'h40);
         ld(A_DAT, 2'h0, v[i]);
         pg(2'(i), 1'b1);
      end
      ld(A_CMD, 2'h0, 8'h04);
      rd(2'h0, "fuse low", v[0]);
      rd(2'h3, "fuse high", v[1]);
      rd(2'h2, "fuse ext", v[2]);
   endtask

   task automatic t_lock();
      ld(A_CMD, 2'h0, 8'h20);
      ld(A_DAT, 2'h0, 8'hfe);
      pg(2'h0, 1'b1);
      ld(A_DAT, 2'h0, 8'hff);
      pg(2'h0, 1'b1);
      ld(A_CMD, 2'h0, 8'h04);
      rd(2'h1, "lock one bit", 8'hfe);
      ld(A_CMD, 2'h0, 8'h20);
      ld(A_DAT, 2'h0, 8'hfd);
      pg(2'h0, 1'b1);
      ld(A_DAT, 2'h0, 8'hc3);
      pg(2'h0, 1'b1);
      ld(A_CMD, 2'h0, 8'h04);
      rd(2'h1, "lock level three", 8'hfc);
      ld(A_CMD, 2'h0, 8'h80);
      pg(2'h0, 1'b1);
      ld(A_CMD, 2'h0, 8'h04);
      rd(2'h1, "lock erased", 8'hff);
      rd(2'h0, "fuse kept", 8'he1);
      ld(A_CMD, 2'h0, 8'h02);
      ld(A_ADR, 2'h0, 8'h08);
      rd(2'h0, "flash erased", 8'hff);
   endtask

   task automatic t_sig();
      logic [7:0] s[3] = '{8'h6b, 8'h27, 8'hc4};
      ld(A_CMD, 2'h0, 8'h08);
      for (int i = 0; i < 3; i++) begin
         ld(A_ADR, 2'h0, 8'(i));
         rd(2'h0, "signature", s[i]);
      end
      ld(A_ADR, 2'h0, 8'h00);
      rd(2'h1, "calibration", CAL);
      ld(A_NOP, 2'h0, 8'h02);
      rd(2'h1, "idle action", CAL);
   endtask

   // whole run needs well under 8000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_mismatch++;
      summarize();
   end

   initial begin
      repeat (5) @(posedge ref_clk_in);
      #2;
      resetn_in = 1'b1;
      ppnvm_prog_model_inst.tick(1);
      t_reset();
      t_flash();
      t_eeprom();
      t_fuse();
      t_lock();
      t_sig();
      summarize();
   end
endmodule
`default_nettype wire
